// >>> mcar_consts.vh
`ifndef MCAR_CONSTS_VH
`define MCAR_CONSTS_VH
// =====================================================
// Register offsets
`define MCAR_ADDR_CTRL_PRI   8'h00
`define MCAR_ADDR_CTRL_SEC   8'h01
`define MCAR_ADDR_SUPPLY1_ALERT_ENABLE     8'h02
`define MCAR_ADDR_SUPPLY1_FAULT_LOG     8'h03
// =====================================================
// Reset values
`define MCAR_RST_CTRL_PRI    8'h00
`define MCAR_RST_CTRL_SEC    8'h00
`define MCAR_RST_SUPPLY1_ALERT_ENABLE      8'h00
`define MCAR_RST_SUPPLY1_FAULT_LOG      8'h00
// =====================================================
// Secondary control fields
`define MCAR_SEC_ALCLR       7
`define MCAR_SEC_COR         5
`define MCAR_SEC_WAKE        4
`define MCAR_SEC_PKRST       3
`define MCAR_SEC_SWRST       0
`define MCAR_SEC_WMASK       8'hb9
// =====================================================
// Primary control fields
`define MCAR_PRI_MODE_HI     6
`define MCAR_PRI_MODE_LO     5
`define MCAR_PRI_SCAN_HI     4
`define MCAR_PRI_SCAN_LO     3
`define MCAR_PRI_SNAP_HI     2
`define MCAR_PRI_SNAP_LO     0
`define MCAR_MODE_SNAPSHOT   2'h1
`define MCAR_SCAN_ALL        2'h0
`define MCAR_SNAP_GPIO_PAIR  3'h7
`define MCAR_SNAP_SENSE_PAIR 3'h6
`endif

// >>> mcar_regs.v
`timescale 1ns/10ps
`include "mcar_consts.vh"

module mcar_regs
(
    // Clock and reset
    input  wire       sys_clk_i,
    input  wire       rst_n_i,
    // Register access port
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output reg  [7:0] reg_rdata_o,
    input  wire       dev_addressed_i,
    // Measurement side
    input  wire [7:0] supply1_fault_events_i,
    input  wire       conv_done_i,
    input  wire       stuck_bus_timeout_i,
    input  wire       shutdown_i,
    // Control outputs
    output reg        alert_n_o,
    output reg        snapshot_start_o,
    output reg        scan_enable_o,
    output reg  [5:0] scan_channel_mask_o,
    output reg  [2:0] snap_channel_o,
    output reg        snap_power_update_o,
    output reg        peak_hold_reset_o,
    output reg        wake_o,
    output reg  [7:0] supply1_fault_bits_o
);

    // =====================================================
    // Reset release
    reg        rst_s1_q;
    reg        rst_s2_q;
    wire       rst_n;

    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // =====================================================
    // Register decode
    reg  [7:0] control_primary_q;
    reg  [7:0] control_secondary_q;
    reg  [7:0] supply1_alert_enable_q;
    reg  [7:0] supply1_fault_log_q;
    reg        alert_q;
    reg        snap_busy_q;

    wire       wr_pri   = reg_wr_i && (reg_addr_i == `MCAR_ADDR_CTRL_PRI);
    wire       wr_sec   = reg_wr_i && (reg_addr_i == `MCAR_ADDR_CTRL_SEC);
    wire       wr_al1   = reg_wr_i && (reg_addr_i == `MCAR_ADDR_SUPPLY1_ALERT_ENABLE);
    wire       wr_f1    = reg_wr_i && (reg_addr_i == `MCAR_ADDR_SUPPLY1_FAULT_LOG);
    wire       rd_f1    = reg_rd_i && (reg_addr_i == `MCAR_ADDR_SUPPLY1_FAULT_LOG);
    // Soft reset
    // soft reset strobe
    wire       soft_rst = wr_sec && reg_wdata_i[`MCAR_SEC_SWRST];
    wire [1:0] mode     = control_primary_q[`MCAR_PRI_MODE_HI:`MCAR_PRI_MODE_LO];
    wire [1:0] scan_sel = control_primary_q[`MCAR_PRI_SCAN_HI:`MCAR_PRI_SCAN_LO];
    wire [2:0] snap_sel = control_primary_q[`MCAR_PRI_SNAP_HI:`MCAR_PRI_SNAP_LO];

    // Fault and enable pairing
    wire [7:0] fault_next;
    wire [7:0] enabled_hit;
    genvar     gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_fault
            assign fault_next[gi] = supply1_fault_events_i[gi] ? 1'b1 :
                                    ((wr_f1 ? reg_wdata_i[gi] : supply1_fault_log_q[gi]) &
                                     ~(rd_f1 & control_secondary_q[`MCAR_SEC_COR]));
            assign enabled_hit[gi] = supply1_fault_events_i[gi] & supply1_alert_enable_q[gi];
        end
    endgenerate

    // =====================================================
    // Registers
    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control_primary_q      <= `MCAR_RST_CTRL_PRI;
            control_secondary_q    <= `MCAR_RST_CTRL_SEC;
            supply1_alert_enable_q <= `MCAR_RST_SUPPLY1_ALERT_ENABLE;
            supply1_fault_log_q    <= `MCAR_RST_SUPPLY1_FAULT_LOG;
            alert_q                <= 1'b0;
            snap_busy_q            <= 1'b0;
        end
        else if (soft_rst)
        begin
            control_primary_q      <= `MCAR_RST_CTRL_PRI;
            control_secondary_q    <= `MCAR_RST_CTRL_SEC;
            supply1_alert_enable_q <= `MCAR_RST_SUPPLY1_ALERT_ENABLE;
            supply1_fault_log_q    <= `MCAR_RST_SUPPLY1_FAULT_LOG;
            alert_q                <= 1'b0;
            snap_busy_q            <= 1'b0;
        end
        else
        begin
            if (wr_pri)
            begin
                control_primary_q <= reg_wdata_i;
            end
            if (wr_sec)
            begin
                control_secondary_q <= reg_wdata_i & `MCAR_SEC_WMASK &
                                       ~(8'h01 << `MCAR_SEC_PKRST);
            end
            if (wr_al1)
            begin
                supply1_alert_enable_q <= reg_wdata_i;
            end
            supply1_fault_log_q <= fault_next;
            if (|enabled_hit)
            begin
                alert_q <= 1'b1;
            end
            else if (dev_addressed_i && control_secondary_q[`MCAR_SEC_ALCLR])
            begin
                alert_q <= 1'b0;
            end
            if (wr_pri && reg_wdata_i[`MCAR_PRI_MODE_HI:`MCAR_PRI_MODE_LO] == `MCAR_MODE_SNAPSHOT)
            begin
                snap_busy_q <= 1'b1;
            end
            else if (conv_done_i)
            begin
                snap_busy_q <= 1'b0;
            end
        end
    end

    // =====================================================
    // Registered outputs
    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_o          <= 8'h00;
            alert_n_o            <= 1'b1;
            snapshot_start_o     <= 1'b0;
            scan_enable_o        <= 1'b0;
            scan_channel_mask_o  <= 6'h00;
            snap_channel_o       <= 3'h0;
            snap_power_update_o  <= 1'b0;
            peak_hold_reset_o    <= 1'b0;
            wake_o               <= 1'b0;
            supply1_fault_bits_o <= 8'h00;
        end
        else
        begin
            case (reg_addr_i)
                `MCAR_ADDR_CTRL_PRI: reg_rdata_o <= control_primary_q;
                `MCAR_ADDR_CTRL_SEC: reg_rdata_o <= control_secondary_q;
                `MCAR_ADDR_SUPPLY1_ALERT_ENABLE:   reg_rdata_o <= supply1_alert_enable_q;
                `MCAR_ADDR_SUPPLY1_FAULT_LOG:   reg_rdata_o <= supply1_fault_log_q;
                default:             reg_rdata_o <= 8'h00;
            endcase
            alert_n_o            <= ~alert_q;
            snapshot_start_o     <= wr_pri && !soft_rst && !snap_busy_q &&
                reg_wdata_i[`MCAR_PRI_MODE_HI:`MCAR_PRI_MODE_LO] == `MCAR_MODE_SNAPSHOT;
            scan_enable_o        <= (mode != `MCAR_MODE_SNAPSHOT);
            case (scan_sel)
                2'h0:    scan_channel_mask_o <= 6'h3f;
                2'h1:    scan_channel_mask_o <= 6'h03;
                2'h2:    scan_channel_mask_o <= 6'h0c;
                default: scan_channel_mask_o <= 6'h3c;
            endcase
            snap_channel_o       <= snap_sel;
            snap_power_update_o  <= (snap_sel == `MCAR_SNAP_GPIO_PAIR) ||
                                    (snap_sel == `MCAR_SNAP_SENSE_PAIR);
            peak_hold_reset_o    <= wr_sec && reg_wdata_i[`MCAR_SEC_PKRST];
            wake_o               <= shutdown_i && stuck_bus_timeout_i &&
                                    control_secondary_q[`MCAR_SEC_WAKE];
            supply1_fault_bits_o <= supply1_fault_log_q;
        end
    end

endmodule // mcar_regs

// >>> mcar_regs_asserts.sv
`timescale 1ns/10ps
module mcar_regs_asserts (
    // Clock, reset, bus
    input wire       sys_clk_i,
    input wire       rst_n_i,
    input wire       reg_wr_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    input wire       dev_addressed_i,
    // Measurement side
    input wire [7:0] supply1_fault_events_i,
    input wire       stuck_bus_timeout_i,
    input wire       shutdown_i,
    // Outputs
    input wire       alert_n_o,
    input wire       snapshot_start_o,
    input wire       scan_enable_o,
    input wire [5:0] scan_channel_mask_o,
    input wire       peak_hold_reset_o,
    input wire       wake_o,
    input wire [7:0] supply1_fault_bits_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_alert_holds: assert property (!alert_n_o && !$past(dev_addressed_i) && !$past(reg_wr_i)
        |=> !alert_n_o) else $error("alert released");
    chk_fault_sets: assert property (supply1_fault_events_i[7]
        |-> ##[1:2] supply1_fault_bits_o[7]) else $error("fault bit unset");
    chk_peak_cause: assert property (peak_hold_reset_o
        |-> $past(reg_wr_i && reg_addr_i == 8'h01 && reg_wdata_i[3])) else $error("peak");
    chk_snap_cause: assert property (snapshot_start_o
        |-> $past(reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[6:5] == 2'h1)) else $error("snap");
    chk_scan_mask: assert property ($past(reg_wr_i && reg_addr_i == 8'h00 &&
        reg_wdata_i[4:3] == 2'h0, 2) |-> scan_channel_mask_o == 6'h3f) else $error("mask");
    chk_wake_cause: assert property (wake_o
        |-> $past(shutdown_i && stuck_bus_timeout_i)) else $error("wake");
    chk_sec_reserved: assert property ($past(reg_addr_i) == 8'h01
        |-> (reg_rdata_o & 8'h4f) == 8'h00) else $error("reserved bits");
    chk_unmapped_zero: assert property ($past(reg_addr_i) > 8'h03
        |-> reg_rdata_o == 8'h00) else $error("unmapped read");
endmodule // mcar_regs_asserts
bind mcar_regs mcar_regs_asserts u_chk (.*);

// >>> mcar_host.sv
`timescale 1ns/10ps
module mcar_host (
    // Bus
    input  wire       sys_clk_i,
    input  wire [7:0] reg_rdata_i,
    output reg        reg_wr_o,
    output reg        reg_rd_o,
    output reg  [7:0] reg_addr_o,
    output reg  [7:0] reg_wdata_o
);
    initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = 18'h0;
    task wr(input [7:0] a, input [7:0] d);
        @(posedge sys_clk_i);
        {reg_wr_o, reg_addr_o, reg_wdata_o} <= {1'b1, a, d};
        @(posedge sys_clk_i);
        {reg_wr_o, reg_wdata_o} <= {1'b0, ~d};
        #1;
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(posedge sys_clk_i);
        {reg_rd_o, reg_addr_o} <= {1'b1, a};
        @(posedge sys_clk_i);
        reg_rd_o <= 1'b0;
        #1 d = reg_rdata_i;
    endtask
endmodule // mcar_host

// >>> test_monitor_control_alert_regs.sv
`timescale 1ns/10ps
module test_monitor_control_alert_regs;
    reg        clk = 1'b0;
    reg        rst_n = 1'b0;
    reg        adr = 1'b0;
    reg        tmo = 1'b0;
    reg        sd = 1'b0;
    reg  [7:0] ev = 8'h00;
    reg  [7:0] v;
    wire       wr, rd, alert_n, snap_st, scan_en, peak, wake;
    wire [7:0] addr, wdata, rdata, fbits;
    wire [5:0] mask;
    wire [2:0] snap_ch;
    wire       snap_pw;
    integer    n_mismatch = 0;
    integer    n_compared = 0;
    integer    i;
    always #20 clk = ~clk;
    mcar_host u_host (.sys_clk_i(clk), .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata));
    mcar_regs u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .dev_addressed_i(adr),
        .supply1_fault_events_i(ev), .conv_done_i(1'b0), .stuck_bus_timeout_i(tmo),
        .shutdown_i(sd), .alert_n_o(alert_n), .snapshot_start_o(snap_st),
        .scan_enable_o(scan_en), .scan_channel_mask_o(mask), .snap_channel_o(snap_ch),
        .snap_power_update_o(snap_pw), .peak_hold_reset_o(peak), .wake_o(wake),
        .supply1_fault_bits_o(fbits));
    task cmp(input [7:0] got, input [7:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rchk(input [7:0] a, input [7:0] exp);
        u_host.rd(a, v);
        cmp(v, exp);
    endtask
    // Drive side inputs and let three edges pass
    task drive(input [7:0] e, input a, input t, input s);
        @(posedge clk);
        {ev, adr, tmo, sd} <= {e, a, t, s};
        repeat (3) @(posedge clk);
        #1;
    endtask
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #100000 n_mismatch = n_mismatch + 1;
        tally_and_finish;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 5; i = i + 1)
            rchk(i[7:0], 8'h00);
        u_host.wr(8'h02, 8'h5a);
        rchk(8'h02, 8'h5a);
        u_host.wr(8'h01, 8'hfe);
        cmp({7'h0, peak}, 8'h01);
        rchk(8'h01, 8'hb0);
        u_host.wr(8'h01, 8'h01);
        rchk(8'h02, 8'h00);
        for (i = 0; i < 4; i = i + 1)
        begin
            u_host.wr(8'h00, 8'(i << 3));
            @(posedge clk);
            #1;
            cmp({2'h0, mask}, 8'(32'h3c0c033f >> (8 * i)));
        end
        for (i = 0; i < 8; i = i + 1)
        begin
            u_host.wr(8'h00, i[7:0]);
            rchk(8'h00, i[7:0]);
            cmp({4'h0, snap_pw, snap_ch}, {4'h0, i >= 6, i[2:0]});
        end
        u_host.wr(8'h00, 8'h20);
        cmp({7'h0, snap_st}, 8'h01);
        @(posedge clk);
        #1;
        cmp({7'h0, scan_en}, 8'h00);
        u_host.wr(8'h02, 8'h7f);
        drive(8'h80, 1'b0, 1'b0, 1'b0);
        cmp({7'h0, alert_n}, 8'h01);
        drive(8'h00, 1'b0, 1'b0, 1'b0);
        u_host.wr(8'h02, 8'h80);
        drive(8'h80, 1'b0, 1'b0, 1'b0);
        cmp({7'h0, alert_n}, 8'h00);
        cmp(fbits, 8'h80);
        drive(8'h00, 1'b1, 1'b0, 1'b0);
        cmp({7'h0, alert_n}, 8'h00);
        drive(8'h00, 1'b0, 1'b0, 1'b0);
        rchk(8'h03, 8'h80);
        rchk(8'h03, 8'h80);
        u_host.wr(8'h01, 8'ha0);
        rchk(8'h03, 8'h80);
        rchk(8'h03, 8'h00);
        drive(8'h00, 1'b1, 1'b0, 1'b0);
        cmp({7'h0, alert_n}, 8'h01);
        u_host.wr(8'h02, 8'h05);
        drive(8'h08, 1'b0, 1'b0, 1'b0);
        cmp({7'h0, alert_n}, 8'h01);
        drive(8'h04, 1'b0, 1'b0, 1'b0);
        cmp({7'h0, alert_n}, 8'h00);
        drive(8'h00, 1'b1, 1'b0, 1'b0);
        cmp({7'h0, alert_n}, 8'h01);
        drive(8'h02, 1'b0, 1'b0, 1'b0);
        cmp({7'h0, alert_n}, 8'h01);
        drive(8'h01, 1'b0, 1'b0, 1'b0);
        cmp({7'h0, alert_n}, 8'h00);
        u_host.wr(8'h01, 8'h10);
        drive(8'h00, 1'b0, 1'b1, 1'b0);
        cmp({7'h0, wake}, 8'h00);
        drive(8'h00, 1'b0, 1'b1, 1'b1);
        cmp({7'h0, wake}, 8'h01);
        tally_and_finish;
    end
endmodule // test_monitor_control_alert_regs
